// >>> rtl/rpi_pkg.sv
// Constants of the periodic interrupt and 32 kHz clock output block.
// Assumes a crystal tick strobe in the system clock domain.
package rpi_pkg;

  // ----------------------------------------------------------------
  // Crystal counts
  // ----------------------------------------------------------------
  localparam int CNT_W = 17;
  localparam logic [16:0] TICKS_32768 = 17'h08000;
  localparam logic [16:0] TICKS_32000 = 17'h07d00;
  localparam logic [16:0] HALF_32768 = 17'h04000;
  // Low phase 0.496 s of a 32.000 kHz second
  localparam logic [16:0] HALF_32000 = 17'h03e00;

  // ----------------------------------------------------------------
  // Trimming
  // ----------------------------------------------------------------
  localparam logic [4:0] TRIM_PERIOD_S = 5'h14;
  // 3.784 ms at 32.768 kHz and 3.875 ms at 32.000 kHz are both 124 ticks
  localparam logic signed [7:0] TRIM_MAX = 8'sh7c;

  // ----------------------------------------------------------------
  // Pulse mode lag behind the seconds increment
  // ----------------------------------------------------------------
  localparam int LAG_US = 92;
  localparam int LAG_TICKS = (LAG_US * 32768) / 1000000;

  // ----------------------------------------------------------------
  // Cycle select codes
  // ----------------------------------------------------------------
  localparam logic [2:0] CYC_OFF = 3'h0;
  localparam logic [2:0] CYC_LOW = 3'h1;
  localparam logic [2:0] CYC_2HZ = 3'h2;
  localparam logic [2:0] CYC_1HZ = 3'h3;
  localparam logic [2:0] CYC_SEC = 3'h4;
  localparam logic [2:0] CYC_MIN = 3'h5;
  localparam logic [2:0] CYC_HOUR = 3'h6;
  localparam logic [2:0] CYC_MONTH = 3'h7;

  // Oscillator-halt flag after a power-on from zero volts
  localparam logic OSC_HALT_RST = 1'b1;

endpackage : rpi_pkg

// >>> rtl/rpi_prescaler.sv
// Seconds divider with trimming and raw pulse-mode waveforms.
// Assumes osc_tick is a one-cycle strobe per crystal period.
`timescale 1ns/1ps
module rpi_prescaler #(
  parameter int CNT_W = rpi_pkg::CNT_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic osc_tick,
  input wire logic xtal_32000,
  input wire logic trim_en,
  input wire logic signed [7:0] trim_delta,
  output logic sec_tick_q,
  output logic wave1_q,
  output logic wave2_q
);

  logic [CNT_W-1:0] pos_q;
  logic [4:0] slot_q;

  // ----------------------------------------------------------------
  // Second length and half point
  // ----------------------------------------------------------------
  // Trim only once per twenty seconds, so the error stays bounded
  wire trim_apply = trim_en && (slot_q == 5'h00);
  wire signed [7:0] dclamp = (trim_delta > rpi_pkg::TRIM_MAX) ? rpi_pkg::TRIM_MAX :
                             (trim_delta < -rpi_pkg::TRIM_MAX) ? -rpi_pkg::TRIM_MAX :
                             trim_delta;
  wire [CNT_W-1:0] adj_w = trim_apply ? {{(CNT_W-8){dclamp[7]}}, dclamp} : '0;
  wire [CNT_W-1:0] base_len = xtal_32000 ? rpi_pkg::TICKS_32000 : rpi_pkg::TICKS_32768;
  wire [CNT_W-1:0] base_half = xtal_32000 ? rpi_pkg::HALF_32000 : rpi_pkg::HALF_32768;
  wire [CNT_W-1:0] len_w = base_len + adj_w;
  wire [CNT_W-1:0] half_w = base_half + adj_w;
  wire [CNT_W-1:0] qa_w = {1'b0, half_w[CNT_W-1:1]};
  wire [CNT_W-1:0] span_w = len_w - half_w;
  wire [CNT_W-1:0] qb_w = half_w + {1'b0, span_w[CNT_W-1:1]};
  wire end_w = (pos_q == len_w - 1'b1);

  // Low phases: 1 Hz low for the first part, 2 Hz low in the first part of each half
  wire low1_w = pos_q < half_w;
  wire low2_w = (pos_q < qa_w) || ((pos_q >= half_w) && (pos_q < qb_w));

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      pos_q <= '0;
      slot_q <= 5'h00;
      sec_tick_q <= 1'b0;
      wave1_q <= 1'b0;
      wave2_q <= 1'b0;
    end else begin
      sec_tick_q <= osc_tick && end_w;
      wave1_q <= low1_w;
      wave2_q <= low2_w;
      if (osc_tick && end_w) begin
        pos_q <= '0;
        slot_q <= (slot_q == rpi_pkg::TRIM_PERIOD_S - 5'h01) ? 5'h00 : slot_q + 5'h01;
      end else if (osc_tick) begin
        pos_q <= pos_q + 1'b1;
      end
    end
  end

endmodule : rpi_prescaler

// >>> rtl/rpi_periodic_irq.sv
// Periodic interrupt, alarm routing and 32 kHz clock output pins.
// Assumes all inputs synchronous to clk_sys; time counters sit outside.
`timescale 1ns/1ps
module rpi_periodic_irq #(
  parameter int CNT_W = rpi_pkg::CNT_W,
  parameter int LAG_TICKS = rpi_pkg::LAG_TICKS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic osc_tick,
  input wire logic osc_level,
  input wire logic xtal_32000,
  input wire logic trim_en,
  input wire logic signed [7:0] trim_delta,
  input wire logic cycle_sel_bit2,
  input wire logic cycle_sel_bit1,
  input wire logic cycle_sel_bit0,
  input wire logic route_sel_bit2,
  input wire logic route_sel_bit1,
  input wire logic clkout_disable,
  input wire logic next_sec_zero,
  input wire logic next_min_zero,
  input wire logic next_hour_zero,
  input wire logic next_day_first,
  input wire logic periodic_flag_clr,
  input wire logic alarm_first_active,
  input wire logic alarm_second_hit,
  input wire logic alarm_second_clr,
  input wire logic osc_halt_detect,
  input wire logic ctrl2_write,
  input wire logic irq_out_first_n_i,
  input wire logic irq_out_second_n_i,
  output logic irq_out_first_n_o,
  output logic irq_out_first_n_oe_n,
  output logic irq_out_second_n_o,
  output logic irq_out_second_n_oe_n,
  output logic sec_tick,
  output logic periodic_irq_flag,
  output logic alarm_second_flag,
  output logic osc_halt_flag,
  output logic init_busy
);

  // ----------------------------------------------------------------
  // Seconds divider
  // ----------------------------------------------------------------
  logic wave1_w;
  logic wave2_w;

  rpi_prescaler #(
    .CNT_W(CNT_W)
  ) u_presc (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .osc_tick(osc_tick),
    .xtal_32000(xtal_32000),
    .trim_en(trim_en),
    .trim_delta(trim_delta),
    .sec_tick_q(sec_tick),
    .wave1_q(wave1_w),
    .wave2_q(wave2_w)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [LAG_TICKS-1:0] dly1_q;
  logic [LAG_TICKS-1:0] dly2_q;
  logic periodic_irq_flag_q;
  logic periodic_irq_flag_d;
  logic alarm_second_flag_q;
  logic alarm_second_flag_d;
  logic osc_halt_flag_q;
  logic osc_halt_flag_d;
  logic busy_q;
  logic first_oe_n_q;
  logic second_oe_n_q;

  // ----------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------
  wire [2:0] code_w = {cycle_sel_bit2, cycle_sel_bit1, cycle_sel_bit0};
  wire level_mode = cycle_sel_bit2;
  wire pulse_2hz = (code_w == rpi_pkg::CYC_2HZ);
  wire pulse_1hz = (code_w == rpi_pkg::CYC_1HZ);
  wire fixed_low = (code_w == rpi_pkg::CYC_LOW);

  // Level-mode event condition, judged on the values after the increment
  wire cond_sec = (code_w == rpi_pkg::CYC_SEC);
  wire cond_min = (code_w == rpi_pkg::CYC_MIN) && next_sec_zero;
  wire cond_hour = (code_w == rpi_pkg::CYC_HOUR) && next_sec_zero
                   && next_min_zero;
  wire cond_month = (code_w == rpi_pkg::CYC_MONTH) && next_sec_zero && next_min_zero
                    && next_hour_zero && next_day_first;
  wire level_event = sec_tick && (cond_sec || cond_min || cond_hour || cond_month);

  // Pulse output after the crystal-tick lag
  wire pulse_low = (pulse_2hz && dly2_q[LAG_TICKS-1])
                   || (pulse_1hz && dly1_q[LAG_TICKS-1]);

  // Periodic source is active low inside; CODE 000 contributes nothing
  wire periodic_low = fixed_low || pulse_low || (level_mode && periodic_irq_flag_q);

  // ----------------------------------------------------------------
  // Pin combining
  // ----------------------------------------------------------------
  // Clock output bypasses trimming: taken straight from the oscillator level
  wire clk32_low = !clkout_disable && !osc_level;
  wire first_low = alarm_first_active
                   || (alarm_second_flag_q && !route_sel_bit1)
                   || (periodic_low && !route_sel_bit2);
  wire second_low = clk32_low
                    || (alarm_second_flag_q && route_sel_bit1)
                    || (periodic_low && route_sel_bit2);

  // ----------------------------------------------------------------
  // Flag next values; an event in the clear cycle wins
  // ----------------------------------------------------------------
  always_comb begin
    periodic_irq_flag_d = periodic_irq_flag_q;
    if (!level_mode) begin
      periodic_irq_flag_d = 1'b0;
    end else if (level_event) begin
      periodic_irq_flag_d = 1'b1;
    end else if (periodic_flag_clr) begin
      periodic_irq_flag_d = 1'b0;
    end
    alarm_second_flag_d = alarm_second_flag_q;
    if (alarm_second_hit) begin
      alarm_second_flag_d = 1'b1;
    end else if (alarm_second_clr) begin
      alarm_second_flag_d = 1'b0;
    end
    osc_halt_flag_d = osc_halt_flag_q;
    if (osc_halt_detect) begin
      osc_halt_flag_d = 1'b1;
    end else if (ctrl2_write) begin
      osc_halt_flag_d = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Lag lines, stepped only on crystal ticks
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      dly1_q <= '0;
      dly2_q <= '0;
    end else if (osc_tick) begin
      dly1_q <= {dly1_q[LAG_TICKS-2:0], wave1_w};
      dly2_q <= {dly2_q[LAG_TICKS-2:0], wave2_w};
    end
  end

  // ----------------------------------------------------------------
  // Flags and initialisation window
  // ----------------------------------------------------------------
  // Busy until the first full second so the bus side can refuse access
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      periodic_irq_flag_q <= 1'b0;
      alarm_second_flag_q <= 1'b0;
      osc_halt_flag_q <= rpi_pkg::OSC_HALT_RST;
      busy_q <= 1'b1;
    end else begin
      periodic_irq_flag_q <= periodic_irq_flag_d;
      alarm_second_flag_q <= alarm_second_flag_d;
      osc_halt_flag_q <= osc_halt_flag_d;
      if (sec_tick) begin
        busy_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Open-drain pin drivers
  // ----------------------------------------------------------------
  // Registered enables; costs one system clock of delay on every edge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      first_oe_n_q <= 1'b1;
      second_oe_n_q <= 1'b1;
    end else begin
      first_oe_n_q <= !first_low;
      second_oe_n_q <= !second_low;
    end
  end

  // Open drain: only ever pulls low, the pull-up gives the high level
  assign irq_out_first_n_o = 1'b0;
  assign irq_out_second_n_o = 1'b0;
  assign irq_out_first_n_oe_n = first_oe_n_q;
  assign irq_out_second_n_oe_n = second_oe_n_q;
  assign periodic_irq_flag = level_mode ? periodic_irq_flag_q : pulse_low;
  assign alarm_second_flag = alarm_second_flag_q;
  assign osc_halt_flag = osc_halt_flag_q;
  assign init_busy = busy_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_fixed_low;
    @(posedge clk_sys) disable iff (!rstn)
      (code_w == rpi_pkg::CYC_LOW) && !route_sel_bit2 |=> !irq_out_first_n_oe_n;
  endproperty
  a_fixed_low: assert property (p_fixed_low) else $error("fixed low not driven");

  property p_off_quiet;
    @(posedge clk_sys) disable iff (!rstn)
      (code_w == rpi_pkg::CYC_OFF) && !alarm_first_active && !alarm_second_flag_q
      ##1 (code_w == rpi_pkg::CYC_OFF) && !alarm_first_active && !alarm_second_flag_q
      |=> irq_out_first_n_oe_n;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("first pin driven while off");

  property p_level_set;
    @(posedge clk_sys) disable iff (!rstn)
      level_event && !route_sel_bit2 ##1 !route_sel_bit2 |=> !irq_out_first_n_oe_n;
  endproperty
  a_level_set: assert property (p_level_set) else $error("level event not on pin");

  property p_sec_event;
    @(posedge clk_sys) disable iff (!rstn)
      sec_tick && (code_w == rpi_pkg::CYC_SEC) |=> periodic_irq_flag;
  endproperty
  a_sec_event: assert property (p_sec_event) else $error("second event missed");

  property p_min_gate;
    @(posedge clk_sys) disable iff (!rstn)
      sec_tick && (code_w == rpi_pkg::CYC_MIN) && !next_sec_zero && !periodic_irq_flag_q
      |=> !periodic_irq_flag_q;
  endproperty
  a_min_gate: assert property (p_min_gate) else $error("minute event off zero");

  property p_flag_clear;
    @(posedge clk_sys) disable iff (!rstn)
      periodic_flag_clr && !level_event |=> !periodic_irq_flag_q;
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag clear ignored");

  property p_set_wins;
    @(posedge clk_sys) disable iff (!rstn)
      alarm_second_hit && alarm_second_clr |=> alarm_second_flag;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("alarm set lost to clear");

  property p_halt_clear;
    @(posedge clk_sys) disable iff (!rstn)
      ctrl2_write && !osc_halt_detect |=> !osc_halt_flag;
  endproperty
  a_halt_clear: assert property (p_halt_clear) else $error("halt flag not cleared");

  property p_clk_pass;
    @(posedge clk_sys) disable iff (!rstn)
      !clkout_disable && !osc_level |=> !irq_out_second_n_oe_n;
  endproperty
  a_clk_pass: assert property (p_clk_pass) else $error("clock output missing");

  property p_route_second;
    @(posedge clk_sys) disable iff (!rstn)
      fixed_low && route_sel_bit2 |=> !irq_out_second_n_oe_n
        && irq_out_first_n_oe_n == !($past(alarm_first_active)
        || ($past(alarm_second_flag_q) && !$past(route_sel_bit1)));
  endproperty
  a_route_second: assert property (p_route_second) else $error("periodic misrouted");

  property p_busy_end;
    @(posedge clk_sys) disable iff (!rstn)
      sec_tick |=> !init_busy;
  endproperty
  a_busy_end: assert property (p_busy_end) else $error("init window not ended");

endmodule : rpi_periodic_irq

// >>> verif/rpi_host_model.sv
// Host side model: pull-ups on both interrupt lines and a periodic flag clear access.
// Assumes the pins are split into o and oe_n, with oe_n low while the device drives.
`timescale 1ns/1ps
module rpi_host_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic first_o,
  input wire logic first_oe_n,
  input wire logic second_o,
  input wire logic second_oe_n,
  input wire logic init_busy,
  input wire logic clr_req,
  output logic first_lvl,
  output logic second_lvl,
  output logic periodic_flag_clr,
  output logic clr_done
);
  // ----------------------------------------------------------------
  // Wired lines
  // ----------------------------------------------------------------
  // Released lines rise through the board pull-up
  assign first_lvl = first_oe_n ? 1'b1 : first_o;
  assign second_lvl = second_oe_n ? 1'b1 : second_o;

  // ----------------------------------------------------------------
  // Flag clear access
  // ----------------------------------------------------------------
  // Held off and retried while the device is still initialising
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      periodic_flag_clr <= 1'b0;
      clr_done <= 1'b0;
    end else begin
      periodic_flag_clr <= clr_req && !init_busy && !clr_done
                           && !periodic_flag_clr;
      clr_done <= clr_req && (clr_done || periodic_flag_clr);
    end
  end
endmodule : rpi_host_model

// >>> verif/testbench.sv
// Self-checking bench for the periodic interrupt and 32 kHz output block.
// Assumes one crystal tick per clk_sys cycle and a 32.000 kHz crystal throughout.
`timescale 1ns/1ps
module testbench;
  logic clk_sys, rstn, osc_tick, osc_level, xtal_32000, trim_en, route_sel_bit2, route_sel_bit1;
  logic signed [7:0] trim_delta;
  logic [2:0] cyc;
  logic clkout_disable, next_sec_zero, alarm_first_active, alarm_second_hit, alarm_second_clr;
  logic osc_halt_detect, ctrl2_write, clr_req;
  wire first_o, first_oe_n, second_o, second_oe_n, sec_tick, periodic_irq_flag;
  wire alarm_second_flag, osc_halt_flag, init_busy, first_lvl, second_lvl, flag_clr, clr_done;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;

  rpi_periodic_irq i_rpi_periodic_irq (.clk_sys(clk_sys), .rstn(rstn), .osc_tick(osc_tick),
    .osc_level(osc_level), .xtal_32000(xtal_32000), .trim_en(trim_en), .trim_delta(trim_delta),
    .cycle_sel_bit2(cyc[2]), .cycle_sel_bit1(cyc[1]), .cycle_sel_bit0(cyc[0]),
    .route_sel_bit2(route_sel_bit2), .route_sel_bit1(route_sel_bit1),
    .clkout_disable(clkout_disable), .next_sec_zero(next_sec_zero), .next_min_zero(1'b0),
    .next_hour_zero(1'b0), .next_day_first(1'b0), .periodic_flag_clr(flag_clr),
    .alarm_first_active(alarm_first_active), .alarm_second_hit(alarm_second_hit),
    .alarm_second_clr(alarm_second_clr), .osc_halt_detect(osc_halt_detect),
    .ctrl2_write(ctrl2_write), .irq_out_first_n_i(first_lvl), .irq_out_second_n_i(second_lvl),
    .irq_out_first_n_o(first_o), .irq_out_first_n_oe_n(first_oe_n),
    .irq_out_second_n_o(second_o), .irq_out_second_n_oe_n(second_oe_n), .sec_tick(sec_tick),
    .periodic_irq_flag(periodic_irq_flag), .alarm_second_flag(alarm_second_flag),
    .osc_halt_flag(osc_halt_flag), .init_busy(init_busy));

  rpi_host_model i_rpi_host_model (.clk_sys(clk_sys), .rstn(rstn), .first_o(first_o),
    .first_oe_n(first_oe_n), .second_o(second_o), .second_oe_n(second_oe_n),
    .init_busy(init_busy), .clr_req(clr_req), .first_lvl(first_lvl), .second_lvl(second_lvl),
    .periodic_flag_clr(flag_clr), .clr_done(clr_done));

  // ----------------------------------------------------------------
  // Clock, crystal level and hang guard
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // Crystal level toggles every cycle so the clock output is easy to count
  always @(negedge clk_sys) osc_level <= ~osc_level;
  // Three seconds of 32000 ticks plus margin
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 100000) begin
      bad_count++;
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize;
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize

  // Bounded wait for the seconds increment; returns at the negedge that shows it
  task automatic wait_tick;
    int n;
    n = 0;
    while (sec_tick !== 1'b1 && n < 40000) begin
      @(negedge clk_sys);
      n++;
    end
    chk("sec_tick seen", 32'(n < 40000), 32'h1);
  endtask : wait_tick

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_clkout;
    int n;
    logic prev;
    chk("halt flag at power-on", osc_halt_flag, 1);
    chk("init busy", init_busy, 1);
    chk("periodic flag off", periodic_irq_flag, 0);
    n = 0;
    prev = second_lvl;
    repeat (8) begin
      @(negedge clk_sys);
      if (second_lvl !== prev) n++;
      prev = second_lvl;
    end
    chk("clock output toggles", n, 8);
    clkout_disable = 1'b1;
    repeat (3) @(negedge clk_sys);
    n = 0;
    repeat (4) begin
      @(negedge clk_sys);
      if (second_lvl !== 1'b1) n++;
    end
    chk("clock output released", n, 0);
  endtask : test_reset_clkout

  // Fixed-low code walked across all four routing codes, then switched off
  task automatic test_fixed_low_routing;
    cyc = rpi_pkg::CYC_LOW;
    for (int r = 0; r < 4; r++) begin
      {route_sel_bit2, route_sel_bit1} = r[1:0];
      repeat (3) @(negedge clk_sys);
      chk("first pin", first_lvl, r[1]);
      chk("second pin", second_lvl, !r[1]);
    end
    {route_sel_bit2, route_sel_bit1} = 2'h0;
    cyc = rpi_pkg::CYC_OFF;
    repeat (3) @(negedge clk_sys);
    chk("first pin off", first_lvl, 1);
  endtask : test_fixed_low_routing

  task automatic test_flags;
    alarm_second_hit = 1'b1;
    @(negedge clk_sys);
    alarm_second_hit = 1'b0;
    alarm_first_active = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk("alarm b flag set", alarm_second_flag, 1);
    alarm_second_clr = 1'b1;
    @(negedge clk_sys);
    alarm_second_clr = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("alarm b flag clear", alarm_second_flag, 0);
    chk("first pin held by alarm a", first_lvl, 0);
    alarm_first_active = 1'b0;
    route_sel_bit1 = 1'b1;
    alarm_second_hit = 1'b1;
    @(negedge clk_sys);
    alarm_second_hit = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("first pin released", first_lvl, 1);
    chk("alarm b on second pin", second_lvl, 0);
    // Set and clear in one cycle: the set must win
    alarm_second_hit = 1'b1;
    alarm_second_clr = 1'b1;
    @(negedge clk_sys);
    alarm_second_hit = 1'b0;
    chk("alarm b set wins", alarm_second_flag, 1);
    @(negedge clk_sys);
    alarm_second_clr = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("second pin released", second_lvl, 1);
    route_sel_bit1 = 1'b0;
    ctrl2_write = 1'b1;
    @(negedge clk_sys);
    ctrl2_write = 1'b0;
    chk("halt flag cleared", osc_halt_flag, 0);
    osc_halt_detect = 1'b1;
    @(negedge clk_sys);
    osc_halt_detect = 1'b0;
    chk("halt flag set again", osc_halt_flag, 1);
  endtask : test_flags

  // Level mode: flag one cycle and pin two cycles after the increment
  task automatic test_level(input logic [2:0] code, input logic clear);
    int n;
    cyc = code;
    wait_tick();
    @(negedge clk_sys);
    chk("level flag", periodic_irq_flag, 1);
    @(negedge clk_sys);
    chk("level pin", first_lvl, 0);
    if (clear) begin
      clr_req = 1'b1;
      n = 0;
      while (clr_done !== 1'b1 && n < 50) begin
        @(negedge clk_sys);
        n++;
      end
      clr_req = 1'b0;
      repeat (3) @(negedge clk_sys);
      chk("busy after first second", init_busy, 0);
      chk("level flag cleared", periodic_irq_flag, 0);
      chk("level pin released", first_lvl, 1);
    end
  endtask : test_level

  // 1 Hz pulse: lag behind the increment and the 0.496 s low phase
  task automatic test_pulse_1hz;
    int n;
    int m;
    cyc = rpi_pkg::CYC_1HZ;
    wait_tick();
    n = 0;
    while (periodic_irq_flag !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    chk("pulse lag in range", 32'(n >= 1 && n <= 8), 32'h1);
    @(negedge clk_sys);
    chk("pulse pin low", first_lvl, 0);
    m = 1;
    while (periodic_irq_flag === 1'b1 && m < 20000) begin
      @(negedge clk_sys);
      m++;
    end
    chk("low phase ticks", m, {15'h0, rpi_pkg::HALF_32000});
    // 2 Hz low phase of the longer second half starts as the 1 Hz low ends
    cyc = rpi_pkg::CYC_2HZ;
    @(negedge clk_sys);
    m = 1;
    while (periodic_irq_flag === 1'b1 && m < 20000) begin
      @(negedge clk_sys);
      m++;
    end
    chk("2hz low ticks", m,
        32'((rpi_pkg::TICKS_32000 - rpi_pkg::HALF_32000) >> 1));
  endtask : test_pulse_1hz

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rstn, osc_level, trim_en, route_sel_bit2, route_sel_bit1, next_sec_zero} = 6'h0;
    {alarm_first_active, alarm_second_hit, alarm_second_clr, osc_halt_detect} = 4'h0;
    {ctrl2_write, clr_req, clkout_disable} = 3'h0;
    osc_tick = 1'b1;
    xtal_32000 = 1'b1;
    trim_delta = 8'sh00;
    cyc = rpi_pkg::CYC_OFF;
    repeat (10) @(negedge clk_sys);
    rstn = 1'b1;
    @(negedge clk_sys);
    test_reset_clkout();
    test_fixed_low_routing();
    test_flags();
    test_level(rpi_pkg::CYC_SEC, 1'b1);
    test_pulse_1hz();
    next_sec_zero = 1'b1;
    test_level(rpi_pkg::CYC_MIN, 1'b0);
    summarize();
  end
endmodule : testbench
